// ---- adcr_consts.vh ----
// constants for the converter control and serial readout block
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH
`define ADCR_RESULT_BITS 12
`define ADCR_LEAD_ZEROS 4
`define ADCR_WORD_BITS 16
`define ADCR_CLK_PERIOD_NS 8
`define ADCR_CONV_TIME_NS 8000
`define ADCR_CONV_CYCLES (`ADCR_CONV_TIME_NS / `ADCR_CLK_PERIOD_NS)
`define ADCR_HOLD_TIME_NS 16
`define ADCR_HOLD_CYCLES ((`ADCR_HOLD_TIME_NS + `ADCR_CLK_PERIOD_NS - 1) / `ADCR_CLK_PERIOD_NS)
`endif

// ---- adcr_sync.v ----
// three-stage synchroniser for one pin input with agreement filter
`timescale 1ns/1ns
`default_nettype none
module adcr_sync #(
    parameter RESET_LEVEL = 1'b0
) (
    input wire sys_clk,
    input wire reset_n,
    input wire pinIn,
    output reg level,
    output wire rise,
    output wire fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts once the second and third stages agree
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
    assign rise = (s2_q == s3_q) && s3_q && !level;
    assign fall = (s2_q == s3_q) && !s3_q && level;
endmodule
`default_nettype wire

// ---- adcr_converter.v ----
// converter control, busy, power-down and serial result readout
// Notes on behaviour
// - convert-start falling edge holds sample, starts conversion
// - convert-start low at finish enters power-down
// - rising convert-start wakes from power-down
// - busy rises on the launching falling edge
// - busy falls when conversion completes
// - sixteen-bit word, four zeros then result
// - after sixteenth falling edge hold, then tristate
// - result is straight unsigned binary
`timescale 1ns/1ns
`default_nettype none
`include "adcr_consts.vh"
module adcr_converter #(
    parameter RESULT_BITS = `ADCR_RESULT_BITS,
    parameter WORD_BITS = `ADCR_WORD_BITS,
    parameter CONV_CYCLES = `ADCR_CONV_CYCLES,
    parameter HOLD_CYCLES = `ADCR_HOLD_CYCLES
) (
    input wire sys_clk,
    input wire reset_n,
    input wire convert_start_n,
    input wire serial_clock,
    input wire [RESULT_BITS-1:0] analogSample,
    output reg busy,
    output reg poweredDown,
    output reg trackHold,
    output reg serial_result_out,
    output reg serialOutEnable
);
    localparam ST_IDLE = 2'b00;
    localparam ST_CONV = 2'b01;
    localparam ST_DOWN = 2'b10;
    localparam CW = 14;
    localparam BW = 5;
    localparam HW = 4;

    wire cvLevel;
    wire cvRise;
    wire cvFall;
    wire skLevel;
    wire skRise;
    wire skFall;
    reg [1:0] state_q;
    reg [CW-1:0] convCnt_q;
    reg [RESULT_BITS-1:0] held_q;
    reg [WORD_BITS-1:0] shift_q;
    reg [BW-1:0] bitCnt_q;
    reg [HW-1:0] holdCnt_q;
    reg holding_q;
    wire convDone;
    // next values of the conversion control registers
    reg [1:0] state_d;
    reg [CW-1:0] convCnt_d;
    reg [RESULT_BITS-1:0] held_d;
    reg busy_d;
    reg poweredDown_d;
    reg trackHold_d;
    // next values of the readout registers
    reg [WORD_BITS-1:0] shift_d;
    reg [BW-1:0] bitCnt_d;
    reg [HW-1:0] holdCnt_d;
    reg holding_d;
    reg serialOut_d;
    reg outEnable_d;

    adcr_sync #(.RESET_LEVEL(1'b1)) syncStart (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinIn(convert_start_n),
        .level(cvLevel),
        .rise(cvRise),
        .fall(cvFall)
    );

    adcr_sync #(.RESET_LEVEL(1'b0)) syncClock (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinIn(serial_clock),
        .level(skLevel),
        .rise(skRise),
        .fall(skFall)
    );

    // conversion time is a fixed count of system clocks from the launch
    assign convDone = (state_q == ST_CONV) && (convCnt_q == CONV_CYCLES[CW-1:0] - 14'h0001);

    // control next state: launch, convert, then idle or power-down
    always @* begin
        state_d = state_q;
        convCnt_d = convCnt_q;
        held_d = held_q;
        busy_d = busy;
        poweredDown_d = poweredDown;
        trackHold_d = trackHold;
        case (state_q)
            ST_IDLE: begin
                // the sample is frozen at launch, so later input changes do not leak in
                if (cvFall) begin
                    state_d = ST_CONV;
                    held_d = analogSample;
                    trackHold_d = 1'b1;
                    busy_d = 1'b1;
                    convCnt_d = {CW{1'b0}};
                end
            end
            ST_CONV: begin
                // launch edges are ignored while a conversion runs
                convCnt_d = convCnt_q + 14'h0001;
                if (convDone) begin
                    busy_d = 1'b0;
                    trackHold_d = 1'b0;
                    // a start pin still low at the end puts the block to sleep
                    if (!cvLevel) begin
                        state_d = ST_DOWN;
                        poweredDown_d = 1'b1;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_DOWN: begin
                // only a rising start pin wakes the block
                if (cvRise) begin
                    state_d = ST_IDLE;
                    poweredDown_d = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            convCnt_q <= {CW{1'b0}};
            held_q <= {RESULT_BITS{1'b0}};
            busy <= 1'b0;
            poweredDown <= 1'b0;
            trackHold <= 1'b0;
        end else begin
            state_q <= state_d;
            convCnt_q <= convCnt_d;
            held_q <= held_d;
            busy <= busy_d;
            poweredDown <= poweredDown_d;
            trackHold <= trackHold_d;
        end
    end

    // readout: word loads at conversion end, bits change on falling clock edges
    // the top bit is a lead zero, so it stands on the line before any clock
    always @* begin
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        holdCnt_d = holdCnt_q;
        holding_d = holding_q;
        serialOut_d = serial_result_out;
        outEnable_d = serialOutEnable;
        if (convDone) begin
            shift_d = {{(WORD_BITS-RESULT_BITS){1'b0}}, held_q};
            bitCnt_d = {BW{1'b0}};
            holding_d = 1'b0;
            outEnable_d = 1'b1;
            serialOut_d = 1'b0;
        end else if (holding_q) begin
            // last bit stays put for the hold count, then the line is let go
            if (holdCnt_q == HOLD_CYCLES[HW-1:0] - 4'h1) begin
                holding_d = 1'b0;
                outEnable_d = 1'b0;
            end else begin
                holdCnt_d = holdCnt_q + 4'h1;
            end
        end else if (serialOutEnable && skFall) begin
            // the final falling edge starts the hold instead of shifting
            if (bitCnt_q == WORD_BITS[BW-1:0] - 5'h01) begin
                holding_d = 1'b1;
                holdCnt_d = {HW{1'b0}};
            end else begin
                shift_d = {shift_q[WORD_BITS-2:0], 1'b0};
                serialOut_d = shift_q[WORD_BITS-2];
                bitCnt_d = bitCnt_q + 5'h01;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            shift_q <= {WORD_BITS{1'b0}};
            bitCnt_q <= {BW{1'b0}};
            holdCnt_q <= {HW{1'b0}};
            holding_q <= 1'b0;
            serial_result_out <= 1'b0;
            serialOutEnable <= 1'b0;
        end else begin
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            holdCnt_q <= holdCnt_d;
            holding_q <= holding_d;
            serial_result_out <= serialOut_d;
            serialOutEnable <= outEnable_d;
        end
    end
endmodule
`default_nettype wire

// ---- adcr_converter_props.sv ----
// port assertions for the converter block
`timescale 1ns/1ns
`default_nettype none
module adcr_converter_props (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic convert_start_n,
    input wire logic serial_clock,
    input wire logic busy,
    input wire logic poweredDown,
    input wire logic trackHold,
    input wire logic serial_result_out,
    input wire logic serialOutEnable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_hold_on_launch: assert property ($rose(busy) |-> trackHold && !$past(convert_start_n))
        else $error("launch bad");
    a_busy_length: assert property ($rose(busy) |=> busy[*8] ##[1:1000] !busy)
        else $error("busy length");
    a_sleep_at_end: assert property ($rose(poweredDown) |-> $fell(busy) && !convert_start_n)
        else $error("sleep bad");
    a_wake_on_rise: assert property ($rose(convert_start_n) && poweredDown |-> ##[1:8] !poweredDown)
        else $error("no wake");
    a_sleep_idle: assert property (poweredDown |-> !busy)
        else $error("busy asleep");
    a_lead_zero: assert property ($fell(busy) |-> serialOutEnable && !serial_result_out)
        else $error("lead bit");
    a_shift_low: assert property (serialOutEnable && $past(serialOutEnable)
        && $changed(serial_result_out) |-> !serial_clock)
        else $error("shift edge");
    a_hold_release: assert property ($fell(serialOutEnable) |->
        $past(serial_result_out) == $past(serial_result_out, 2))
        else $error("no hold");
endmodule
bind adcr_converter adcr_converter_props u_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .convert_start_n(convert_start_n), .serial_clock(serial_clock), .busy(busy),
    .poweredDown(poweredDown), .trackHold(trackHold), .serial_result_out(serial_result_out),
    .serialOutEnable(serialOutEnable));
`default_nettype wire

// ---- adcr_host_model.sv ----
// host model: convert-start pulses and gated sixteen-pulse readout
`timescale 1ns/1ns
`default_nettype none
module adcr_host_model (
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic serial_result_out,
    output logic convert_start_n,
    output logic serial_clock
);
    initial begin
        convert_start_n = 1'b1;
        serial_clock = 1'b0;
    end
    task automatic convert(input logic stayLow, output logic ok);
        int n = 0;
        @(posedge sys_clk);
        #1 convert_start_n = 1'b0;
        while (!busy && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (!stayLow) convert_start_n = 1'b1;
        while (busy && n < 1500) begin
            @(posedge sys_clk);
            #1 n++;
        end
        ok = !busy;
    endtask
    task automatic wake();
        @(posedge sys_clk);
        #1 convert_start_n = 1'b1;
    endtask
    // clock stays low between frames, as the gate output does
    task automatic readout(output logic [15:0] w);
        for (int i = 0; i < 16; i++) begin
            #40 serial_clock = 1'b1;
            w = {w[14:0], serial_result_out};
            #40 serial_clock = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- test_adc_convert_and_serial_readout.sv ----
// bench for the converter control and serial readout block
`timescale 1ns/1ns
`default_nettype none
module test_adc_convert_and_serial_readout;
    logic sys_clk, reset_n, cs, sck, busy, pd, th, sd, sdEn, ok;
    logic [11:0] sample;
    logic [15:0] word;
    logic [11:0] rows [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};
    int bad_count = 0, cmp_count = 0, cycles = 0;
    adcr_converter #(.CONV_CYCLES(50)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
        .convert_start_n(cs), .serial_clock(sck), .analogSample(sample), .busy(busy),
        .poweredDown(pd), .trackHold(th), .serial_result_out(sd), .serialOutEnable(sdEn));
    adcr_host_model host (.sys_clk(sys_clk), .busy(busy), .serial_result_out(sd),
        .convert_start_n(cs), .serial_clock(sck));
    task automatic check(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cycles > 20000) begin
        bad_count++;
        end_sim();
    end
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        sample = 12'h000;
        repeat (2) @(posedge sys_clk);
        #1 check({busy, pd, th, sdEn, sd} === 5'h00, "reset outputs");
        reset_n = 1'b1;
        foreach (rows[i]) begin
            sample = rows[i];
            host.convert(1'b0, ok);
            check(ok === 1'b1, "busy stuck");
            check(pd === 1'b0, "slept");
            check(th === 1'b0, "sample still held");
            host.readout(word);
            check(word === {4'h0, rows[i]}, "word");
            repeat (8) @(posedge sys_clk);
            #1 check(sdEn === 1'b0, "not released");
        end
        host.convert(1'b1, ok);
        check(pd === 1'b1, "no sleep");
        host.wake();
        repeat (8) @(posedge sys_clk);
        #1 check(pd === 1'b0, "no wake");
        end_sim();
    end
endmodule
`default_nettype wire
